/* bench/deser_port_gpio_bc_ctrl_bench.sv */
// bench joining both link ends: register port, output states, back channel
module deser_port_gpio_bc_ctrl_bench
  import dspgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
  failures++; $display("MISMATCH %s expected %0h seen %0h", n, e, a); end end
  logic       core_clk = 1'b0, reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic       reg_wr = 1'b0, reg_rd = 1'b0, power_down_n = 1'b0;
  logic       mode_strap_one = 1'b0, downstream_irq_n = 1'b1, pass_i = 1'b0;
  logic [3:0] gpio_i = 4'h8, hs_gpio_i = 4'hF, s_gi = 4'h1, s_hi = 4'h0;
  logic [3:0] gpio_o, gpio_oe_n, hs_gpio_o, hs_gpio_oe_n, s_go, s_goe, s_ho;
  logic       lock_o, lock_oe_n, pass_o, pass_oe_n, csi_hs0_o, csi_oe_n;
  logic       serial_active = 1'b0, two_lane = 1'b0, irq_fwd_en = 1'b1;
  logic       isr_rd = 1'b0, remote_irq_n, irq_status;
  logic [2:0] hs_mode = 3'h0;
  logic [2:0] modes [4] = '{3'h0, 3'h3, 3'h2, 3'h1};
  logic [7:0] rate_v [4] = '{8'h40, 8'h00, 8'h50, 8'h10};
  int         half_v [4] = '{2, 4, 1, 1};
  int         failures = 0, compares = 0, n;
  wire [10:0] all_oe_n = {lock_oe_n, pass_oe_n, csi_oe_n, gpio_oe_n,
                          hs_gpio_oe_n};

  dspgc_link_if lk ();
  dspgc_deser_end dspgc_deser_end_inst (.core_clk, .reset_n, .link(lk),
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .power_down_n,
    .mode_strap_one, .downstream_irq_n, .pass_i, .gpio_i, .gpio_o,
    .gpio_oe_n, .hs_gpio_i, .hs_gpio_o, .hs_gpio_oe_n, .lock_o, .lock_oe_n,
    .pass_o, .pass_oe_n, .csi_hs0_o, .csi_oe_n);
  dspgc_ser_end dspgc_ser_end_inst (.core_clk, .reset_n, .link(lk),
    .serial_active, .two_lane, .ser_gpio_cfg(16'h5003), .hs_mode,
    .irq_fwd_en, .isr_rd, .gpio_i(s_gi), .gpio_o(s_go), .gpio_oe_n(s_goe),
    .hs_gpio_i(s_hi), .hs_gpio_o(s_ho), .remote_irq_n, .irq_status);
  dspgc_link_props dspgc_link_props_inst (.core_clk, .reset_n,
    .bc_clk(lk.bc_clk), .bc_frame(lk.bc_frame), .bc_data(lk.bc_data),
    .fwd_active(lk.fwd_active), .fwd_two_lane(lk.fwd_two_lane),
    .fwd_gpio(lk.fwd_gpio), .fwd_hs_gpio(lk.fwd_hs_gpio));

  always #25 core_clk = ~core_clk;

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 `CHK($sformatf("reg %0h", a), e, reg_rdata)
  endtask
  task automatic wirq(input logic e);
    for (int i = 0; i < 1000 && remote_irq_n !== e; i++) cyc(1);
    `CHK("remote_irq_n", e, remote_irq_n)
    if (remote_irq_n !== e) tally_and_finish;
  endtask
  // a rate change may cut the current phase short, so skip one edge first
  task automatic hp(output int k);
    logic v;
    cyc(1);
    v = lk.bc_clk;
    for (int i = 0; i < 20 && lk.bc_clk === v; i++) cyc(1);
    v = lk.bc_clk;
    for (k = 0; k < 20 && lk.bc_clk === v; k++) cyc(1);
    // a link clock that never toggles would stall every later check
    if (k >= 20) begin
      failures++;
      tally_and_finish;
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    failures++;
    tally_and_finish;
  end

  initial begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    cyc(6);
    `CHK("all_oe_n", 11'h7FF, all_oe_n)
    rc(8'h34, 8'h01);
    rc(8'h23, 8'h00);
    rc(8'h43, 8'h00);
    rc(8'h50, 8'h00);
    wr(8'h02, 8'hFF);
    rc(8'h02, 8'h90);
    wr(8'h02, 8'h00);
    wr(8'h34, 8'h03);
    wr(8'h1D, 8'h05);
    wr(8'h34, 8'h01);
    wr(8'h1D, 8'h09);
    rc(8'h1D, 8'h09);
    wr(8'h34, 8'h02);
    rc(8'h1D, 8'h05);
    wr(8'h34, 8'h03);
    rc(8'h1D, 8'h05);
    wr(8'h34, 8'h01);
    wr(8'h1D, 8'h05);
    wr(8'h23, 8'h00);
    @(posedge core_clk);
    power_down_n <= 1'b1;
    serial_active <= 1'b1;
    cyc(10);
    `CHK("lock_oe_n", 1'b1, lock_oe_n)
    `CHK("quiet", 4'h2, {pass_o, pass_oe_n, csi_hs0_o, csi_oe_n})
    cyc(60);
    `CHK("lock", 2'h2, {lock_o, lock_oe_n})
    wr(8'h02, 8'h10);
    cyc(3);
    `CHK("sleep_z", 2'h3, {pass_oe_n, csi_oe_n})
    wr(8'h1E, 8'h91);
    wr(8'h1F, 8'h03);
    wr(8'h02, 8'h90);
    pass_i <= 1'b1;
    cyc(6);
    `CHK("valid", 3'h4, {pass_o, csi_hs0_o, csi_oe_n})
    `CHK("gpio", 7'h45, {gpio_oe_n, gpio_o[2:0]})
    wr(8'h02, 8'h80);
    cyc(4);
    `CHK("locked_low", 2'h1, {pass_o, csi_hs0_o})
    @(posedge core_clk);
    serial_active <= 1'b0;
    cyc(8);
    `CHK("static_lock", 2'h0, {lock_o, lock_oe_n})
    `CHK("static_data", 9'h000, {hs_gpio_oe_n, hs_gpio_o, pass_o})
    cyc(600);
    `CHK("ser_gpio", 5'h0F, {s_goe, s_go[3]})
    rc(8'h6E, 8'h08);
    @(posedge core_clk);
    downstream_irq_n <= 1'b0;
    wirq(1'b0);
    `CHK("irq_status", 1'b1, irq_status)
    @(posedge core_clk);
    downstream_irq_n <= 1'b1;
    cyc(600);
    `CHK("irq_held", 1'b0, remote_irq_n)
    @(posedge core_clk);
    isr_rd <= 1'b1;
    @(posedge core_clk);
    isr_rd <= 1'b0;
    cyc(2);
    `CHK("irq_clear", 2'h2, {remote_irq_n, irq_status})
    @(posedge core_clk);
    downstream_irq_n <= 1'b0;
    wirq(1'b0);
    wr(8'h34, 8'h02);
    wr(8'h1D, 8'h03);
    cyc(600);
    `CHK("hs_one_lane", 4'h0, s_ho)
    @(posedge core_clk);
    two_lane <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(8'h43, {5'h00, modes[i]});
      hs_mode <= modes[i];
      hs_gpio_i <= {4{~i[0]}};
      cyc(600);
      `CHK("hs_gpio", ~i[0], s_ho[0])
      rc(8'h43, {5'h00, modes[i]});
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h23, rate_v[i]);
      hp(n);
      `CHK("half_period", half_v[i], n)
      rc(8'h23, rate_v[i]);
    end
    // second reset with the strap high: fast link, register bit untouched
    @(posedge core_clk);
    reset_n <= 1'b0;
    mode_strap_one <= 1'b1;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    rc(8'h34, 8'h01);
    hp(n);
    `CHK("strap_half", 1, n)
    rc(8'h23, 8'h00);
    tally_and_finish;
  end
endmodule

/* bench/dspgc_link_props.sv */
// checker on the link between the two ends: framing and lane rules
module dspgc_link_props (
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       bc_clk,
  input wire logic       bc_frame,
  input wire logic       bc_data,
  input wire logic       fwd_active,
  input wire logic       fwd_two_lane,
  input wire logic [3:0] fwd_gpio,
  input wire logic [3:0] fwd_hs_gpio
);
  logic       seen_q;
  logic [8:0] gap_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // the first frame after reset has no earlier start to measure from
  always_ff @(posedge core_clk) begin
    if (!reset_n) seen_q <= 1'b0;
    else if ($rose(bc_frame)) seen_q <= 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) gap_q <= 9'h000;
    else if ($rose(bc_frame)) gap_q <= 9'h001;
    else if (gap_q != 9'h1FF) gap_q <= gap_q + 9'h001;
  end

  a_data_on_fall: assert property (
    $changed(bc_data) |-> $fell(bc_clk)) else $error("data off clock fall");
  a_frame_on_fall: assert property (
    $changed(bc_frame) |-> $fell(bc_clk)) else $error("frame off clock fall");
  a_clk_high_len: assert property (
    $rose(bc_clk) |-> ##[1:4] $fell(bc_clk)) else $error("clock high too long");
  a_clk_low_len: assert property (
    $fell(bc_clk) |-> ##[1:4] $rose(bc_clk)) else $error("clock low too long");
  a_frame_one_bit: assert property (
    $rose(bc_frame) |-> ##[1:8] $fell(bc_frame)) else $error("frame mark long");
  a_frame_gap_min: assert property (
    $fell(bc_frame) |-> !bc_frame [*8]) else $error("frame mark too soon");
  a_frame_period: assert property (
    $rose(bc_frame) && seen_q |-> gap_q >= 9'h03A && gap_q <= 9'h0E8)
    else $error("frame period out of range");
  a_hs_one_lane: assert property (
    !fwd_two_lane |-> fwd_hs_gpio == 4'h0) else $error("fast gpio in one lane");
endmodule

/* hdl/dspgc_deser_end.sv */
// deserializer end: registers, output states, gpio and back channel
// How it works
// - port select bits steer duplicated register access
// - duplicated read returns selected copy, port1 wins
// - duplicated write updates every selected port copy
// - power-down low tri-states every output
// - lock rises only after locking completes
// - output enable clear: drive low or float, lock pin driven once locked
// - output enable set: outputs follow lock, sleep
// - downstream interrupt level rides back channel
// - serializer holds its interrupt until status read
// - downstream holds interrupt low until source cleared
// - fast gpio works only in two-lane mode
// - port select picks standard or fast gpio
// - nibble 5 forward output, 3 back input
// - serializer mirrors nibbles: 3 input, 5 output
// - pin levels readable, pins locally drivable
// - divider select: divide four or two
// - fast bit or strap forces divide one
// - host programs slow rate for older serializers
// - normal mode: four fast gpio, one sample
// - back frame carries interrupt, gpio, fast samples
//
// The address-and-strobe port was chosen for this implementation.
module dspgc_deser_end
  import dspgc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  dspgc_link_if.deser     link,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       power_down_n,
  input  wire logic       mode_strap_one,
  input  wire logic       downstream_irq_n,
  input  wire logic       pass_i,
  input  wire logic [3:0] gpio_i,
  output logic      [3:0] gpio_o,
  output logic      [3:0] gpio_oe_n,
  input  wire logic [3:0] hs_gpio_i,
  output logic      [3:0] hs_gpio_o,
  output logic      [3:0] hs_gpio_oe_n,
  output logic            lock_o,
  output logic            lock_oe_n,
  output logic            pass_o,
  output logic            pass_oe_n,
  output logic            csi_hs0_o,
  output logic            csi_oe_n
);

  // drive of one gpio pin from its nibble: {oe_n, level}
  function automatic logic [1:0] pin_drive(input logic [3:0] nib,
                                           input logic       fwd);
    case (nib)
      NIB_FWD_OUT:  pin_drive = {1'b0, fwd};
      NIB_LOCAL_LO: pin_drive = 2'h0;
      NIB_LOCAL_HI: pin_drive = 2'h1;
      default:      pin_drive = 2'h2;
    endcase
  endfunction

  logic [20:0] async_in;
  logic [20:0] meta_q;
  logic [20:0] sync_q;
  logic        pdb_s;
  logic        strap_s;
  logic        irq_s;
  logic        active_s;
  logic        two_lane_s;
  logic [3:0]  gpio_s;
  logic [3:0]  hs_s;
  logic [3:0]  fwd_gpio_s;
  logic [3:0]  fwd_hs_s;

  assign async_in = {power_down_n, mode_strap_one, downstream_irq_n,
                     link.fwd_active, link.fwd_two_lane, gpio_i,
                     hs_gpio_i, link.fwd_gpio, link.fwd_hs_gpio};

  for (genvar i = 0; i < 21; i++) begin : g_sync
    always_ff @(posedge core_clk) begin
      if (!reset_n) begin
        meta_q[i] <= DESER_SYNC_RST[i];
        sync_q[i] <= DESER_SYNC_RST[i];
      end else begin
        meta_q[i] <= async_in[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign pdb_s      = sync_q[20];
  assign strap_s    = sync_q[19];
  assign irq_s      = sync_q[18];
  assign active_s   = sync_q[17];
  assign two_lane_s = sync_q[16];
  assign gpio_s     = sync_q[15:12];
  assign hs_s       = sync_q[11:8];
  assign fwd_gpio_s = sync_q[7:4];
  assign fwd_hs_s   = sync_q[3:0];

  // registers
  logic [7:0]  out_state_q;
  logic [7:0]  bc_rate_q;
  logic [1:0]  port_sel_q;
  logic [2:0]  hs_mode_q;
  logic [23:0] cfg_q [2];
  logic [1:0]  strap_wait_q;
  logic        strap_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      out_state_q <= OUT_STATE_RST;
      bc_rate_q   <= BC_RATE_RST;
      port_sel_q  <= PORT_SEL_RST;
      hs_mode_q   <= HS_MODE_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_OUT_STATE: out_state_q <= reg_wdata & OUT_STATE_MASK;
        ADDR_BC_RATE:   bc_rate_q   <= reg_wdata & BC_RATE_MASK;
        ADDR_PORT_SEL:  port_sel_q  <= reg_wdata[1:0];
        ADDR_HS_CTL:    hs_mode_q   <= reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  // port 0 copy configures standard gpio, port 1 copy the fast gpio
  for (genvar p = 0; p < 2; p++) begin : g_cfg
    always_ff @(posedge core_clk) begin
      if (!reset_n) begin
        cfg_q[p] <= GPIO_CFG_RST;
      end else if (reg_wr && port_sel_q[p]) begin
        case (reg_addr)
          ADDR_GPIO0_CFG:  cfg_q[p][7:0]   <= reg_wdata;
          ADDR_GPIO12_CFG: cfg_q[p][15:8]  <= reg_wdata;
          ADDR_GPIO3_CFG:  cfg_q[p][23:16] <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // read data stand only in the cycle after the strobe
  logic rport;
  assign rport = port_sel_q[1];

  always_ff @(posedge core_clk) begin
    if (!reset_n || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        ADDR_OUT_STATE:  reg_rdata <= out_state_q;
        ADDR_BC_RATE:    reg_rdata <= bc_rate_q;
        ADDR_PORT_SEL:   reg_rdata <= {6'h00, port_sel_q};
        ADDR_HS_CTL:     reg_rdata <= {5'h00, hs_mode_q};
        ADDR_GPIO0_CFG:  reg_rdata <= cfg_q[rport][7:0];
        ADDR_GPIO12_CFG: reg_rdata <= cfg_q[rport][15:8];
        ADDR_GPIO3_CFG:  reg_rdata <= cfg_q[rport][23:16];
        ADDR_PIN_STATE:  reg_rdata <= {4'h0, rport ? hs_s : gpio_s};
        default:         reg_rdata <= 8'h00;
      endcase
    end
  end

  // strap is caught once, after the synchroniser has settled
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      strap_wait_q <= 2'h0;
      strap_q      <= 1'b0;
    end else if (strap_wait_q != STRAP_WAIT) begin
      strap_wait_q <= strap_wait_q + 2'h1;
      strap_q      <= strap_s;
    end
  end

  // back-channel divider and link clock
  logic [2:0] div;
  logic [2:0] div_cnt_q;
  logic [4:0] idx_q;
  logic [4:0] idx_nxt;
  logic [4:0] slot;
  logic [1:0] gidx;
  logic [1:0] gk;
  logic       bit_val;

  always_comb begin
    if (bc_rate_q[BC_FAST_BIT] || strap_q) begin
      div = BC_DIV_FAST;
    end else if (bc_rate_q[BC_DIV_BIT]) begin
      div = BC_DIV_MID;
    end else begin
      div = BC_DIV_SLOW;
    end
  end

  assign idx_nxt = (idx_q == FRAME_LEN - 5'h01) ? FRAME_IRQ_POS
                                                 : idx_q + 5'h01;
  assign slot = idx_nxt - FRAME_HS_POS;
  assign gidx = slot[1:0] & dspgc_hs_mask(hs_mode_q);
  assign gk   = 2'(idx_nxt - FRAME_GPIO_POS);

  // content of the bit that starts at the next falling edge
  always_comb begin
    bit_val = 1'b0;
    if (idx_nxt == FRAME_IRQ_POS) begin
      bit_val = irq_s;
    end else if (idx_nxt < FRAME_HS_POS) begin
      bit_val = (dspgc_nib(cfg_q[0], gk) == NIB_BC_IN) & gpio_s[gk];
    end else if (two_lane_s && slot < dspgc_hs_used(hs_mode_q)) begin
      bit_val = (dspgc_nib(cfg_q[1], gidx) == NIB_BC_IN) & hs_s[gidx];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n || !pdb_s) begin
      div_cnt_q     <= 3'h0;
      link.bc_clk   <= 1'b0;
      link.bc_frame <= 1'b0;
      link.bc_data  <= 1'b0;
      idx_q         <= FRAME_LEN - 5'h01;
    end else if (div_cnt_q >= div - 3'h1) begin
      div_cnt_q   <= 3'h0;
      link.bc_clk <= !link.bc_clk;
      if (link.bc_clk) begin
        // data change on the falling edge, sampled on the rising one
        idx_q         <= idx_nxt;
        link.bc_data  <= bit_val;
        link.bc_frame <= (idx_nxt == FRAME_IRQ_POS);
      end
    end else begin
      div_cnt_q <= div_cnt_q + 3'h1;
    end
  end

  // lock sequence
  logic [LOCK_CNT_W-1:0] lock_cnt_q;
  logic                  locked_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n || !pdb_s || !active_s) begin
      lock_cnt_q <= '0;
      locked_q   <= 1'b0;
    end else if (lock_cnt_q == LOCK_CNT_W'(LOCK_CYC - 1)) begin
      locked_q <= 1'b1;
    end else begin
      lock_cnt_q <= lock_cnt_q + 1'b1;
    end
  end

  // output state
  dspgc_out_t state;
  logic       sleep;
  assign sleep = out_state_q[SLEEP_SEL_BIT];

  always_comb begin
    if (!pdb_s) begin
      state = OS_OFF;
    end else if (!out_state_q[OUT_EN_BIT]) begin
      state = sleep ? OS_QUIET_Z : OS_QUIET_LOW;
    end else if (!locked_q) begin
      state = OS_STATIC;
    end else begin
      state = sleep ? OS_VALID : OS_LOCKED_LOW;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lock_o       <= 1'b0;
      lock_oe_n    <= 1'b1;
      pass_o       <= 1'b0;
      pass_oe_n    <= 1'b1;
      gpio_o       <= 4'h0;
      gpio_oe_n    <= 4'hF;
      hs_gpio_o    <= 4'h0;
      hs_gpio_oe_n <= 4'hF;
      csi_hs0_o    <= 1'b0;
      csi_oe_n     <= 1'b1;
    end else begin
      // default: lock pin shows locked_q, everything else driven low, lanes at HS-0
      lock_o       <= locked_q;
      lock_oe_n    <= 1'b0;
      pass_o       <= 1'b0;
      pass_oe_n    <= 1'b0;
      gpio_o       <= 4'h0;
      gpio_oe_n    <= 4'h0;
      hs_gpio_o    <= 4'h0;
      hs_gpio_oe_n <= 4'h0;
      csi_hs0_o    <= 1'b1;
      csi_oe_n     <= 1'b0;
      unique case (state)
        OS_OFF: begin
          lock_o       <= 1'b0;
          lock_oe_n    <= 1'b1;
          pass_oe_n    <= 1'b1;
          gpio_oe_n    <= 4'hF;
          hs_gpio_oe_n <= 4'hF;
          csi_hs0_o    <= 1'b0;
          csi_oe_n     <= 1'b1;
        end
        OS_QUIET_LOW: begin
          lock_oe_n <= !locked_q;
        end
        OS_QUIET_Z: begin
          lock_oe_n    <= !locked_q;
          pass_oe_n    <= 1'b1;
          gpio_oe_n    <= 4'hF;
          hs_gpio_oe_n <= 4'hF;
          csi_hs0_o    <= 1'b0;
          csi_oe_n     <= 1'b1;
        end
        OS_STATIC: begin
          if (sleep) begin
            pass_o <= pass_o;
          end
        end
        OS_LOCKED_LOW: begin
        end
        OS_VALID: begin
          pass_o    <= pass_i;
          csi_hs0_o <= 1'b0;
          for (int k = 0; k < 4; k++) begin
            {gpio_oe_n[k], gpio_o[k]} <=
              pin_drive(dspgc_nib(cfg_q[0], 2'(k)), fwd_gpio_s[k]);
            // fast pins float in single-lane mode
            {hs_gpio_oe_n[k], hs_gpio_o[k]} <= two_lane_s ?
              pin_drive(dspgc_nib(cfg_q[1], 2'(k)), fwd_hs_s[k]) : 2'h2;
          end
        end
      endcase
    end
  end

endmodule

/* hdl/dspgc_link_if.sv */
// serial link between deserializer end and serializer end
interface dspgc_link_if;
  logic       bc_clk;
  logic       bc_frame;
  logic       bc_data;
  logic       fwd_active;
  logic       fwd_two_lane;
  logic [3:0] fwd_gpio;
  logic [3:0] fwd_hs_gpio;

  modport deser (
    output bc_clk, bc_frame, bc_data,
    input  fwd_active, fwd_two_lane, fwd_gpio, fwd_hs_gpio
  );
  modport ser (
    input  bc_clk, bc_frame, bc_data,
    output fwd_active, fwd_two_lane, fwd_gpio, fwd_hs_gpio
  );
endinterface

/* hdl/dspgc_pkg.sv */
// shared constants, types and helpers for both ends of the link
package dspgc_pkg;
  // register offsets
  localparam logic [7:0] ADDR_OUT_STATE  = 8'h02;
  localparam logic [7:0] ADDR_GPIO0_CFG  = 8'h1D;
  localparam logic [7:0] ADDR_GPIO12_CFG = 8'h1E;
  localparam logic [7:0] ADDR_GPIO3_CFG  = 8'h1F;
  localparam logic [7:0] ADDR_BC_RATE    = 8'h23;
  localparam logic [7:0] ADDR_PORT_SEL   = 8'h34;
  localparam logic [7:0] ADDR_HS_CTL     = 8'h43;
  localparam logic [7:0] ADDR_PIN_STATE  = 8'h6E;

  // field positions and writable masks
  localparam int         OUT_EN_BIT    = 7;
  localparam int         SLEEP_SEL_BIT = 4;
  localparam int         BC_DIV_BIT    = 6;
  localparam int         BC_FAST_BIT   = 4;
  localparam logic [7:0] OUT_STATE_MASK = 8'h90;
  localparam logic [7:0] BC_RATE_MASK   = 8'h50;

  // reset values
  localparam logic [7:0]  OUT_STATE_RST = 8'h00;
  localparam logic [7:0]  BC_RATE_RST   = 8'h00;
  localparam logic [1:0]  PORT_SEL_RST  = 2'h1;
  localparam logic [2:0]  HS_MODE_RST   = 3'h0;
  localparam logic [23:0] GPIO_CFG_RST  = 24'h000000;
  localparam logic [20:0] DESER_SYNC_RST = 21'h040000;
  localparam logic [10:0] SER_SYNC_RST   = 11'h000;

  // gpio configuration nibbles
  localparam logic [3:0] NIB_FWD_OUT    = 4'h5;
  localparam logic [3:0] NIB_BC_IN      = 4'h3;
  localparam logic [3:0] NIB_LOCAL_LO   = 4'h1;
  localparam logic [3:0] NIB_LOCAL_HI   = 4'h9;
  localparam logic [3:0] SER_NIB_FWD_IN = 4'h3;
  localparam logic [3:0] SER_NIB_BC_OUT = 4'h5;

  // fast control channel modes
  localparam logic [2:0] HS_MODE_NORMAL = 3'h0;
  localparam logic [2:0] HS_MODE_FAST4  = 3'h3;
  localparam logic [2:0] HS_MODE_FAST2  = 3'h2;
  localparam logic [2:0] HS_MODE_FAST1  = 3'h1;
  localparam int HS_CNT_NORMAL = 4;
  localparam int HS_SPF_NORMAL = 1;
  localparam int HS_CNT_FAST4  = 4;
  localparam int HS_SPF_FAST4  = 6;
  localparam int HS_CNT_FAST2  = 2;
  localparam int HS_SPF_FAST2  = 10;
  localparam int HS_CNT_FAST1  = 1;
  localparam int HS_SPF_FAST1  = 15;

  // back-channel frame layout
  localparam logic [4:0] FRAME_LEN      = 5'h1D;
  localparam logic [4:0] FRAME_IRQ_POS  = 5'h00;
  localparam logic [4:0] FRAME_GPIO_POS = 5'h01;
  localparam logic [4:0] FRAME_HS_POS   = 5'h05;

  // oscillator dividers
  localparam logic [2:0] BC_DIV_SLOW = 3'h4;
  localparam logic [2:0] BC_DIV_MID  = 3'h2;
  localparam logic [2:0] BC_DIV_FAST = 3'h1;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int LOCK_TIME_NS  = 2000;
  localparam int LOCK_CYC   = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_CNT_W = 6;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  typedef enum logic [5:0] {
    OS_OFF        = 6'h01,
    OS_QUIET_LOW  = 6'h02,
    OS_QUIET_Z    = 6'h04,
    OS_STATIC     = 6'h08,
    OS_LOCKED_LOW = 6'h10,
    OS_VALID      = 6'h20
  } dspgc_out_t;

  function automatic logic [3:0] dspgc_nib(input logic [23:0] cfg,
                                           input logic [1:0]  k);
    unique case (k)
      2'h0:    dspgc_nib = cfg[3:0];
      2'h1:    dspgc_nib = cfg[11:8];
      2'h2:    dspgc_nib = cfg[15:12];
      default: dspgc_nib = cfg[19:16];
    endcase
  endfunction

  function automatic logic [4:0] dspgc_hs_used(input logic [2:0] mode);
    case (mode)
      HS_MODE_NORMAL: dspgc_hs_used = 5'(HS_CNT_NORMAL * HS_SPF_NORMAL);
      HS_MODE_FAST4:  dspgc_hs_used = 5'(HS_CNT_FAST4 * HS_SPF_FAST4);
      HS_MODE_FAST2:  dspgc_hs_used = 5'(HS_CNT_FAST2 * HS_SPF_FAST2);
      HS_MODE_FAST1:  dspgc_hs_used = 5'(HS_CNT_FAST1 * HS_SPF_FAST1);
      default:        dspgc_hs_used = 5'h00;
    endcase
  endfunction

  function automatic logic [1:0] dspgc_hs_mask(input logic [2:0] mode);
    case (mode)
      HS_MODE_FAST2: dspgc_hs_mask = 2'(HS_CNT_FAST2 - 1);
      HS_MODE_FAST1: dspgc_hs_mask = 2'(HS_CNT_FAST1 - 1);
      default:       dspgc_hs_mask = 2'(HS_CNT_NORMAL - 1);
    endcase
  endfunction
endpackage

/* hdl/dspgc_ser_end.sv */
// serializer end: back-channel receiver, interrupt and gpio mirror
module dspgc_ser_end
  import dspgc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  dspgc_link_if.ser        link,
  input  wire logic        serial_active,
  input  wire logic        two_lane,
  input  wire logic [15:0] ser_gpio_cfg,
  input  wire logic [2:0]  hs_mode,
  input  wire logic        irq_fwd_en,
  input  wire logic        isr_rd,
  input  wire logic [3:0]  gpio_i,
  output logic      [3:0]  gpio_o,
  output logic      [3:0]  gpio_oe_n,
  input  wire logic [3:0]  hs_gpio_i,
  output logic      [3:0]  hs_gpio_o,
  output logic             remote_irq_n,
  output logic             irq_status
);

  logic [10:0] async_in;
  logic [10:0] meta_q;
  logic [10:0] sync_q;
  logic        clk_s;
  logic        frame_s;
  logic        data_s;
  logic [3:0]  gpio_s;
  logic [3:0]  hs_s;

  assign async_in = {link.bc_clk, link.bc_frame, link.bc_data,
                     gpio_i, hs_gpio_i};

  for (genvar i = 0; i < 11; i++) begin : g_sync
    always_ff @(posedge core_clk) begin
      if (!reset_n) begin
        meta_q[i] <= SER_SYNC_RST[i];
        sync_q[i] <= SER_SYNC_RST[i];
      end else begin
        meta_q[i] <= async_in[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign clk_s   = sync_q[10];
  assign frame_s = sync_q[9];
  assign data_s  = sync_q[8];
  assign gpio_s  = sync_q[7:4];
  assign hs_s    = sync_q[3:0];

  // forward channel toward the deserializer
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      link.fwd_active   <= 1'b0;
      link.fwd_two_lane <= 1'b0;
      link.fwd_gpio     <= 4'h0;
      link.fwd_hs_gpio  <= 4'h0;
    end else begin
      link.fwd_active   <= serial_active;
      link.fwd_two_lane <= two_lane;
      link.fwd_hs_gpio  <= two_lane ? hs_s : 4'h0;
      for (int k = 0; k < 4; k++) begin
        link.fwd_gpio[k] <=
          (ser_gpio_cfg[4*k +: 4] == SER_NIB_FWD_IN) & gpio_s[k];
      end
    end
  end

  // back-channel receiver
  logic       clk_d_q;
  logic       rise;
  logic [4:0] idx_q;
  logic [4:0] idx;
  logic [4:0] slot;
  logic [1:0] gidx;
  logic [1:0] gk;
  logic       rx_irq_q;
  logic [3:0] bc_gpio_q;
  logic       irq_event;

  assign rise = clk_s & !clk_d_q;
  assign idx  = frame_s ? FRAME_IRQ_POS :
                (idx_q == FRAME_LEN - 5'h01) ? idx_q : idx_q + 5'h01;
  assign slot = idx - FRAME_HS_POS;
  assign gidx = slot[1:0] & dspgc_hs_mask(hs_mode);
  assign gk   = 2'(idx - FRAME_GPIO_POS);
  // only a fresh falling edge counts, a held low is one event
  assign irq_event = rise && idx == FRAME_IRQ_POS && irq_fwd_en &&
                     rx_irq_q && !data_s;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      clk_d_q   <= 1'b0;
      idx_q     <= FRAME_LEN - 5'h01;
      rx_irq_q  <= 1'b1;
      bc_gpio_q <= 4'h0;
      hs_gpio_o <= 4'h0;
    end else begin
      clk_d_q <= clk_s;
      if (rise) begin
        idx_q <= idx;
        if (idx == FRAME_IRQ_POS) begin
          rx_irq_q <= data_s;
        end else if (idx < FRAME_HS_POS) begin
          bc_gpio_q[gk] <= data_s;
        end else if (two_lane && slot < dspgc_hs_used(hs_mode)) begin
          hs_gpio_o[gidx] <= data_s;
        end
      end
    end
  end

  // sticky status: a new event beats a status read in the same cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq_status   <= 1'b0;
      remote_irq_n <= 1'b1;
    end else if (irq_event) begin
      irq_status   <= 1'b1;
      remote_irq_n <= 1'b0;
    end else if (isr_rd) begin
      irq_status   <= 1'b0;
      remote_irq_n <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      gpio_o    <= 4'h0;
      gpio_oe_n <= 4'hF;
    end else begin
      for (int k = 0; k < 4; k++) begin
        gpio_oe_n[k] <= ser_gpio_cfg[4*k +: 4] != SER_NIB_BC_OUT;
        gpio_o[k]    <= bc_gpio_q[k];
      end
    end
  end

endmodule
